// >>> hw/bridge_event_status.sv
// Event status, enable and read-request registers of the bridge, on an AHB-Lite slave.
//
// Operation
// - Master write start on a common-bus endpoint sets the read-error flag, bit 29.
// - A change of the VBUS detect level that holds for two clocks sets bit 28.
// - Bit 25, read-only, sets when a requested read lands in the read value register.
// - Bit 24 sets when a core register read or write completes.
// - Bit 23 sets on an AHB error during a master read transfer.
// - Bit 22 sets when the master read transmit FIFO becomes writable.
// - Bit 21 sets when a master read transfer completes.
// - Bit 20 sets on master write AHB error; software then resets that block.
// - Bit 19 sets when a master write transfer times out.
// - Bit 18 sets when a master write transfer completes.
// - Bit 17 sets when receive data arrives while master write is disabled.
// - Bit 10 sets when the core releases bus reset, stays clear until next release.
// - Core registers reinitialise after bus reset release; bit 10 marks that moment.
// - Bit 9 sets when the core asserts bus reset; live level in power control.
// - Bit 8 sets on each suspend change; live level in power control.
// - Each flag interrupts only when its enable bit is one; bit 29 enable included.
`timescale 1ns/10ps
module bridge_event_status
  import bridge_event_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire engine_events_t events_i,
  input wire logic ep_bus_sel_i,
  input wire logic mrd_fifo_writable_i,
  input wire logic core_usb_reset_i,
  input wire logic core_suspend_b_i,
  input wire logic vbus_detect_input_i,
  output logic dmac_rd_req_o,
  output logic [31:0] dmac_rd_addr_o,
  input wire logic dmac_rd_done_i,
  input wire logic [31:0] dmac_rd_data_i,
  output logic mrd_block_reset_o,
  output logic mwr_block_reset_o,
  output logic mwr_enable_o,
  output logic irq_o
);

  // Elaboration check: the offset decoder needs at least one byte of address.
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 8 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic wr_pend_q;
  logic [11:0] wr_ofs_q;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] enable_q;
  logic [31:0] read_val_q;
  logic [2:0] mset_q;
  read_state_t rd_state_q;
  logic vbus_level;
  logic usb_reset_q;
  logic suspend_b_q;
  logic vbus_q;
  logic fifo_wr_q;
  logic armed_q;

  // Only word transfers are served; a narrower write is dropped rather than half-applied.
  function automatic logic word_access(input logic [1:0] trans, input logic [2:0] size);
    word_access = (trans == HTRANS_NONSEQ || trans == HTRANS_SEQ) && size == HSIZE_WORD;
  endfunction

  // Offset compare shared by the read decoder and every register write.
  function automatic logic hit(input logic [11:0] ofs, input logic [11:0] reg_ofs);
    hit = (ofs == reg_ofs);
  endfunction

  logic addr_take;
  logic [11:0] addr_ofs;
  logic wr_en;

  // Only the low twelve address bits decode; a wider bus sees the block repeat every 4 KB.
  assign addr_ofs = 12'(haddr_i);
  assign addr_take = hsel_i && hready_i && word_access(htrans_i, hsize_i);
  assign wr_en = wr_pend_q;

  // Write data arrives one cycle after its address, so offset and direction are kept for it.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 12'h000;
    end else if (hready_i) begin
      wr_pend_q <= addr_take && hwrite_i;
      wr_ofs_q <= addr_ofs;
    end
  end

  // Zero wait states; read data is sampled at the address phase, so a read right after
  // a write to the same register returns the value from before that write.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (addr_take && !hwrite_i) begin
        if (hit(addr_ofs, OFS_STATUS)) begin
          hrdata_o <= status_q & STATUS_IMPL_MASK;
        end else if (hit(addr_ofs, OFS_ENABLE)) begin
          hrdata_o <= enable_q;
        end else if (hit(addr_ofs, OFS_MASTER_SET)) begin
          hrdata_o <= {29'h0000_0000, mset_q[MSET_MWR_ENABLE], 2'h0};
        end else if (hit(addr_ofs, OFS_READ_REQ)) begin
          hrdata_o <= dmac_rd_addr_o;
        end else if (hit(addr_ofs, OFS_READ_VAL)) begin
          hrdata_o <= read_val_q;
        end else if (hit(addr_ofs, OFS_POWER_CTL)) begin
          // Power control is read-only and reports the registered live levels.
          hrdata_o <= {29'h0000_0000, vbus_q, suspend_b_q, usb_reset_q};
        end else begin
          hrdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Enable bits exist only where a flag does; the rest read back as zero.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      enable_q <= ENABLE_RESET;
    end else if (wr_en && hit(wr_ofs_q, OFS_ENABLE)) begin
      enable_q <= hwdata_i & STATUS_IMPL_MASK;
    end
  end

  // The two block resets are strobes: they clear themselves one cycle after the write.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mset_q <= MSET_RESET[2:0];
    end else begin
      mset_q[MSET_MWR_RESET] <= 1'b0;
      mset_q[MSET_MRD_RESET] <= 1'b0;
      if (wr_en && hit(wr_ofs_q, OFS_MASTER_SET)) begin
        mset_q <= hwdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mrd_block_reset_o <= 1'b0;
      mwr_block_reset_o <= 1'b0;
      mwr_enable_o <= 1'b0;
    end else begin
      mrd_block_reset_o <= mset_q[MSET_MRD_RESET];
      mwr_block_reset_o <= mset_q[MSET_MWR_RESET];
      mwr_enable_o <= mset_q[MSET_MWR_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read request path.

  // A new request also clears the completion flag, so an old result is never taken as new.
  logic req_write;
  assign req_write = wr_en && hit(wr_ofs_q, OFS_READ_REQ);

  // A request written while one is outstanding is dropped, not held until the first completes.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rd_state_q <= RD_IDLE;
      dmac_rd_req_o <= 1'b0;
      dmac_rd_addr_o <= 32'h0000_0000;
      read_val_q <= 32'h0000_0000;
    end else begin
      dmac_rd_req_o <= 1'b0;
      case (rd_state_q)
        RD_IDLE: begin
          if (req_write) begin
            dmac_rd_addr_o <= hwdata_i;
            dmac_rd_req_o <= 1'b1;
            rd_state_q <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (dmac_rd_done_i) begin
            read_val_q <= dmac_rd_data_i;
            rd_state_q <= RD_DONE;
          end
        end
        RD_DONE: begin
          // One quiet cycle keeps a back-to-back request from racing the capture.
          rd_state_q <= RD_IDLE;
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level tracking and edge detection.

  // VBUS is the only asynchronous input; the core side shares this clock.
  pin_sync #(
    .RESET_LEVEL(1'b0)
  ) vbus_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .async_i(vbus_detect_input_i),
    .level_o(vbus_level)
  );

  // Edges are only reported one cycle after reset, once the history holds real levels.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      armed_q <= 1'b0;
      usb_reset_q <= 1'b0;
      suspend_b_q <= 1'b1;
      vbus_q <= 1'b0;
      fifo_wr_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      usb_reset_q <= core_usb_reset_i;
      suspend_b_q <= core_suspend_b_i;
      vbus_q <= vbus_level;
      fifo_wr_q <= mrd_fifo_writable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  // Edge flags compare against the last cycle's level; pulse inputs set their flag directly.
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[BIT_MWR_RERR] = events_i.mwr_start && !ep_bus_sel_i;
    set_vec[BIT_VBUS] = armed_q && (vbus_level != vbus_q);
    set_vec[BIT_DMAC_RD] = rd_state_q == RD_WAIT && dmac_rd_done_i;
    set_vec[BIT_CORE_RA] = events_i.core_rd_done || events_i.core_wr_done;
    set_vec[BIT_MRD_BERR] = events_i.mrd_bus_error;
    set_vec[BIT_MRD_FIFO] = armed_q && mrd_fifo_writable_i && !fifo_wr_q;
    set_vec[BIT_MRD_DONE] = events_i.mrd_done;
    set_vec[BIT_MWR_BERR] = events_i.mwr_bus_error;
    set_vec[BIT_MWR_TOUT] = events_i.mwr_timeout;
    set_vec[BIT_MWR_DONE] = events_i.mwr_done;
    set_vec[BIT_MWR_AREQ] = events_i.mwr_rx_data && !mset_q[MSET_MWR_ENABLE];
    set_vec[BIT_RST_END] = armed_q && usb_reset_q && !core_usb_reset_i;
    set_vec[BIT_RST_BEG] = armed_q && !usb_reset_q && core_usb_reset_i;
    set_vec[BIT_SUSP] = armed_q && (suspend_b_q != core_suspend_b_i);
  end

  // Software clears by writing ones; bit 25 is cleared only by a new read request.
  always_comb begin
    clr_vec = 32'h0000_0000;
    if (wr_en && hit(wr_ofs_q, OFS_STATUS)) begin
      clr_vec = hwdata_i & STATUS_W1C_MASK;
    end
    if (req_write && rd_state_q == RD_IDLE) begin
      clr_vec[BIT_DMAC_RD] = 1'b1;
    end
  end

  // A set in the same cycle as its clear wins, so no event is lost.
  assign status_d = ((status_q & ~clr_vec) | set_vec) & STATUS_IMPL_MASK;

  // Reserved positions are masked off in status_d, so writes there never stick.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // The interrupt is registered: it trails the flag by one cycle but never glitches.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & enable_q);
    end
  end

endmodule

// >>> hw/bridge_event_pkg.sv
// Register map, field positions and event carrier for the bridge event status block.
package bridge_event_pkg;

  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_ENABLE = 12'h004;
  localparam logic [11:0] OFS_MASTER_SET = 12'h010;
  localparam logic [11:0] OFS_READ_REQ = 12'h014;
  localparam logic [11:0] OFS_READ_VAL = 12'h018;
  localparam logic [11:0] OFS_POWER_CTL = 12'h080;

  localparam int BIT_MWR_RERR = 29;
  localparam int BIT_VBUS = 28;
  localparam int BIT_DMAC_RD = 25;
  localparam int BIT_CORE_RA = 24;
  localparam int BIT_MRD_BERR = 23;
  localparam int BIT_MRD_FIFO = 22;
  localparam int BIT_MRD_DONE = 21;
  localparam int BIT_MWR_BERR = 20;
  localparam int BIT_MWR_TOUT = 19;
  localparam int BIT_MWR_DONE = 18;
  localparam int BIT_MWR_AREQ = 17;
  localparam int BIT_RST_END = 10;
  localparam int BIT_RST_BEG = 9;
  localparam int BIT_SUSP = 8;

  // Flags that software may clear by writing one; bit 25 is not among them.
  localparam logic [31:0] STATUS_W1C_MASK = 32'h31fe_0700;
  // Every implemented flag, also the width of the enable register.
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h33fe_0700;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

  localparam int MSET_MWR_RESET = 0;
  localparam int MSET_MRD_RESET = 1;
  localparam int MSET_MWR_ENABLE = 2;
  localparam logic [31:0] MSET_RESET = 32'h0000_0000;

  localparam int PWC_USB_RESET = 0;
  localparam int PWC_SUSPEND_B = 1;
  localparam int PWC_VBUS = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // One-cycle event strobes from the master read and write engines and the core access path.
  typedef struct packed {
    logic mwr_start;
    logic mwr_bus_error;
    logic mwr_timeout;
    logic mwr_done;
    logic mwr_rx_data;
    logic mrd_bus_error;
    logic mrd_done;
    logic core_rd_done;
    logic core_wr_done;
  } engine_events_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_DONE = 3'b100
  } read_state_t;

endpackage

// >>> hw/pin_sync.sv
// Three-stage synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic level_o
);

  logic meta_q;
  logic mid_q;
  logic last_q;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_q <= RESET_LEVEL;
      mid_q <= RESET_LEVEL;
      last_q <= RESET_LEVEL;
    end else begin
      meta_q <= async_i;
      mid_q <= meta_q;
      last_q <= mid_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      level_o <= RESET_LEVEL;
    end else if (mid_q == last_q) begin
      level_o <= last_q;
    end
  end

endmodule

// >>> tb/bridge_event_status_sva.sv
// Port-level assertions and covers for the bridge event status block.
`timescale 1ns/10ps
module bridge_event_status_chk
  import bridge_event_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic dmac_rd_req_o,
  input wire logic [31:0] dmac_rd_addr_o,
  input wire logic mrd_block_reset_o,
  input wire logic mwr_block_reset_o,
  input wire logic mwr_enable_o,
  input wire logic irq_o
);
  logic wd_q;
  logic [ADDR_W-1:0] wa_q;
  logic [31:0] en_q;
  logic [31:0] ms_q;
  logic [31:0] rq_q;
  // Shadows of the written registers, so outputs can be tied to what software wrote.
  always_ff @(posedge clock_i) begin
    wa_q <= haddr_i;
    if (!rst_b_i) begin
      wd_q <= 1'b0;
      en_q <= '0;
      ms_q <= '0;
      rq_q <= '0;
    end else begin
      wd_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && (hsize_i == HSIZE_WORD);
      if (wd_q && wa_q == OFS_ENABLE) en_q <= hwdata_i & STATUS_IMPL_MASK;
      if (wd_q && wa_q == OFS_MASTER_SET) ms_q <= hwdata_i;
      if (wd_q && wa_q == OFS_READ_REQ) rq_q <= hwdata_i;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  chk_req_pulse: assert property (dmac_rd_req_o |=> !dmac_rd_req_o)
    else $error("read request longer than one cycle");
  chk_req_addr: assert property (dmac_rd_req_o |-> dmac_rd_addr_o == rq_q)
    else $error("read request address differs from written value");
  chk_mrd_pulse: assert property (mrd_block_reset_o |=> !mrd_block_reset_o)
    else $error("master read reset strobe too long");
  chk_mrd_cause: assert property (mrd_block_reset_o |-> ms_q[MSET_MRD_RESET])
    else $error("master read reset without request");
  chk_mwr_strobe: assert property ($rose(mwr_block_reset_o) |-> ms_q[MSET_MWR_RESET] ##1
    !mwr_block_reset_o)
    else $error("master write reset strobe wrong");
  chk_mwr_enable: assert property ($changed(mwr_enable_o) |->
    mwr_enable_o == ms_q[MSET_MWR_ENABLE])
    else $error("master write enable differs from setting");
  chk_irq_gated: assert property (irq_o |-> (en_q | $past(en_q)) != 0)
    else $error("interrupt with no enable bit set");
  chk_start_quiet: assert property ($rose(rst_b_i) |-> !irq_o && !dmac_rd_req_o)
    else $error("outputs active right after reset");
  cover property (dmac_rd_req_o);
  cover property ($rose(irq_o));
  cover property (mwr_block_reset_o);
endmodule

bind bridge_event_status bridge_event_status_chk #(.ADDR_W(ADDR_W)) chk_u (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .dmac_rd_req_o(dmac_rd_req_o), .dmac_rd_addr_o(dmac_rd_addr_o),
  .mrd_block_reset_o(mrd_block_reset_o), .mwr_block_reset_o(mwr_block_reset_o),
  .mwr_enable_o(mwr_enable_o), .irq_o(irq_o));

// >>> tb/core_read_partner.sv
// Behavioural core side that answers read requests, promptly or slowly.
`timescale 1ns/10ps
module core_read_partner #(
  parameter logic [31:0] KEY = 32'h5a5a_a5a5
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic slow_i,
  output logic done_o = 1'b0,
  output logic [31:0] data_o = 32'h0000_0000
);
  int cnt;
  logic [31:0] a;
  // Data toggles outside the done cycle so a late capture cannot pass by luck.
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (!rst_b_i) begin
      cnt <= 0;
    end else if (req_i) begin
      a <= addr_i;
      cnt <= slow_i ? 6 : 2;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
      data_o <= a ^ KEY;
    end
  end
endmodule

// >>> tb/bridge_event_status_tb.sv
// Self-checking bench for the bridge event status block.
`timescale 1ns/10ps
module bridge_event_status_tb;
  import bridge_event_pkg::*;
  localparam logic [31:0] KEY = 32'h5a5a_a5a5;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  engine_events_t events_i = '0;
  logic ep_bus_sel_i = 1'b0;
  logic mrd_fifo_writable_i = 1'b0;
  logic core_usb_reset_i = 1'b0;
  logic core_suspend_b_i = 1'b1;
  logic vbus_detect_input_i = 1'b0;
  logic slow = 1'b0;
  logic [31:0] hrdata_o, dmac_rd_addr_o, dmac_rd_data_i, r, a, seen;
  logic hreadyout_o, hresp_o, dmac_rd_req_o, dmac_rd_done_i, sel, en;
  logic mrd_block_reset_o, mwr_block_reset_o, mwr_enable_o, irq_o;
  int fails = 0;
  int num_checks = 0;
  integer seed = 32'hfc16dc91;
  int i, k;
  always #10 clock_i = ~clock_i;
  bridge_event_status dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .events_i(events_i),
    .ep_bus_sel_i(ep_bus_sel_i), .mrd_fifo_writable_i(mrd_fifo_writable_i),
    .core_usb_reset_i(core_usb_reset_i), .core_suspend_b_i(core_suspend_b_i),
    .vbus_detect_input_i(vbus_detect_input_i), .dmac_rd_req_o(dmac_rd_req_o),
    .dmac_rd_addr_o(dmac_rd_addr_o), .dmac_rd_done_i(dmac_rd_done_i),
    .dmac_rd_data_i(dmac_rd_data_i), .mrd_block_reset_o(mrd_block_reset_o),
    .mwr_block_reset_o(mwr_block_reset_o), .mwr_enable_o(mwr_enable_o), .irq_o(irq_o));
  core_read_partner #(.KEY(KEY)) partner_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .req_i(dmac_rd_req_o), .addr_i(dmac_rd_addr_o), .slow_i(slow),
    .done_o(dmac_rd_done_i), .data_o(dmac_rd_data_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= ad;
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= w;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    if (w) hwdata_i <= d;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    r = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0);
  endtask
  // Waits past the VBUS synchroniser, reads the flags, then clears all of them but bit 25.
  task automatic ev_chk(input logic [31:0] exp);
    repeat (6) @(posedge clock_i);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(r, exp);
    ahb(1'b1, OFS_STATUS, 32'hffff_ffff);
  endtask
  function automatic logic [31:0] exp_ev(int e, logic s, logic me);
    case (e)
      8: return s ? 32'h0 : 32'h1 << BIT_MWR_RERR;
      7: return 32'h1 << BIT_MWR_BERR;
      6: return 32'h1 << BIT_MWR_TOUT;
      5: return 32'h1 << BIT_MWR_DONE;
      4: return me ? 32'h0 : 32'h1 << BIT_MWR_AREQ;
      3: return 32'h1 << BIT_MRD_BERR;
      2: return 32'h1 << BIT_MRD_DONE;
      default: return 32'h1 << BIT_CORE_RA;
    endcase
  endfunction
  task end_sim;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    ahb(1'b0, OFS_ENABLE, 32'h0);
    chk(r, ENABLE_RESET);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(r, STATUS_RESET);
    ahb(1'b0, 12'h00c, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, OFS_STATUS, 32'hffff_ffff);
    ev_chk(32'h0);
    for (i = 0; i < 24; i++) begin
      k = (i < 9) ? i : $unsigned($random(seed)) % 9;
      sel = 1'($random(seed));
      en = 1'($random(seed));
      ep_bus_sel_i <= sel;
      ahb(1'b1, OFS_MASTER_SET, {29'h0, en, 2'h0});
      events_i <= engine_events_t'(9'h1 << k);
      @(posedge clock_i);
      events_i <= '0;
      ev_chk(exp_ev(k, sel, en));
    end
    ahb(1'b1, OFS_MASTER_SET, 32'h0);
    core_usb_reset_i <= 1'b1;
    ev_chk(32'h1 << BIT_RST_BEG);
    core_usb_reset_i <= 1'b0;
    ev_chk(32'h1 << BIT_RST_END);
    core_suspend_b_i <= 1'b0;
    ev_chk(32'h1 << BIT_SUSP);
    core_suspend_b_i <= 1'b1;
    ev_chk(32'h1 << BIT_SUSP);
    mrd_fifo_writable_i <= 1'b1;
    ev_chk(32'h1 << BIT_MRD_FIFO);
    mrd_fifo_writable_i <= 1'b0;
    ev_chk(32'h0);
    vbus_detect_input_i <= 1'b1;
    ev_chk(32'h1 << BIT_VBUS);
    vbus_detect_input_i <= 1'b0;
    ev_chk(32'h1 << BIT_VBUS);
    ahb(1'b0, OFS_POWER_CTL, 32'h0);
    chk(r, 32'h1 << PWC_SUSPEND_B);
    ahb(1'b1, OFS_ENABLE, 32'hffff_ffff);
    ahb(1'b0, OFS_ENABLE, 32'h0);
    chk(r, STATUS_IMPL_MASK);
    events_i <= engine_events_t'(9'h004);
    @(posedge clock_i);
    events_i <= '0;
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    ahb(1'b1, OFS_ENABLE, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    for (i = 0; i < 2; i++) begin
      ahb(1'b1, OFS_MASTER_SET, 32'h1 << i);
      seen = 32'h0;
      repeat (4) begin
        @(posedge clock_i);
        seen = seen | {31'h0, (i == 1) ? mrd_block_reset_o : mwr_block_reset_o};
      end
      chk(seen, 32'h1);
    end
    for (i = 0; i < 3; i++) begin
      slow <= i[0];
      a = $random(seed);
      ahb(1'b1, OFS_READ_REQ, a);
      r = 32'h0;
      while (r[BIT_DMAC_RD] !== 1'b1) ahb(1'b0, OFS_STATUS, 32'h0);
      ahb(1'b0, OFS_READ_VAL, 32'h0);
      chk(r, a ^ KEY);
      ahb(1'b1, OFS_STATUS, 32'h1 << BIT_DMAC_RD);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(r & (32'h1 << BIT_DMAC_RD), 32'h1 << BIT_DMAC_RD);
    end
    end_sim;
  end
endmodule
